// ---- src/tcc_pkg.sv ----
// Purpose: Constants for the timer compare/capture channel
// Assumes: 16-bit register port, byte addresses as printed
// Notes: Control word at the channel control offset holds reset and run bits
package tcc_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] CHAN_CTL_ADDR = 16'h5460;
   localparam logic [ADDR_W-1:0] COUNT_ADDR = 16'h5462;
   localparam logic [ADDR_W-1:0] CC_CTL_ADDR = 16'h5464;
   localparam logic [ADDR_W-1:0] UNIT_A_ADDR = 16'h5466;
   localparam logic [ADDR_W-1:0] UNIT_B_ADDR = 16'h5468;
   // Channel control fields
   localparam int RUN_BIT = 0;
   localparam int RST_BIT = 1;
   // Compare/capture control fields
   localparam int UNIT_A_SEL_BIT = 0;
   localparam int OUT_A_FLIP_BIT = 1;
   localparam int OUT_A_MODE_LSB = 4;
   localparam int UNIT_A_EDGE_LSB = 6;
   localparam int UNIT_B_SEL_BIT = 8;
   localparam int OUT_B_FLIP_BIT = 9;
   localparam int OUT_B_MODE_LSB = 12;
   localparam int UNIT_B_EDGE_LSB = 14;
   localparam logic [DATA_W-1:0] CC_CTL_MASK = 16'hf3f3;
   localparam logic [DATA_W-1:0] ZERO16 = 16'h0000;
   localparam logic [DATA_W-1:0] ONE16 = 16'h0001;
   localparam logic [DATA_W-1:0] MAX16 = 16'hffff;
   // Capture edge codes
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // Output waveform modes
   localparam logic [1:0] WAVE_OFF = 2'h0;
   localparam logic [1:0] WAVE_A_SET_B_CLR = 2'h1;
   localparam logic [1:0] WAVE_A_TOGGLE = 2'h2;
   localparam logic [1:0] WAVE_B_TOGGLE = 2'h3;
endpackage

// ---- src/tcc_channel.sv ----
// Purpose: One 16-bit timer channel with compare/capture units A and B
// Assumes: Count clock tick input is one-cycle pulse synchronous to core clock
// Notes: Register reads return data in the cycle after the read strobe
// Operation
// [RL1] Writing one to counter reset clears counter; zero ignored; reads show busy
// [RL2] Unit B capture edge: 3 both, 2 falling, 1 rising, 0 none
// [RL3] Unit B select bit one captures, zero compares; resets to zero
// [RL4] Unit A capture edge uses the same encoding as unit B
// [RL5] Unit A select bit one captures, zero compares; resets to zero
// [RL6] Unit A value is 16-bit read/write, resets to zero
// [RL7] Each output follows its mode from compare matches, inverted when flip set
`timescale 1ns/10ps
module tcc_channel (
   input wire logic CORE_CLK_IN,
   input wire logic RESET_IN,
   input wire logic COUNT_TICK_IN,
   input wire logic CAPTURE_A_IN,
   input wire logic CAPTURE_B_IN,
   input wire logic [tcc_pkg::ADDR_W-1:0] ADDR_IN,
   input wire logic [tcc_pkg::DATA_W-1:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [tcc_pkg::DATA_W-1:0] RDATA_OUT,
   output logic TIMER_OUTPUT_A_OUT,
   output logic TIMER_OUTPUT_B_OUT
);
   import tcc_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic edge_hit(input logic [1:0] code, input logic prev,
                                     input logic cur);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = prev & ~cur;
      unique case (code)
         EDGE_NONE: edge_hit = 1'b0;
         EDGE_RISE: edge_hit = rise;
         EDGE_FALL: edge_hit = fall;
         EDGE_BOTH: edge_hit = rise | fall;
      endcase
   endfunction

   // Set on one match, toggle or clear as the mode asks
   function automatic logic wave_next(input logic [1:0] mode, input logic cur,
                                      input logic hit_a, input logic hit_b);
      wave_next = cur;
      unique case (mode)
         WAVE_OFF: wave_next = 1'b0;
         WAVE_A_SET_B_CLR: begin
            if (hit_b) begin
               wave_next = 1'b0;
            end else if (hit_a) begin
               wave_next = 1'b1;
            end
         end
         WAVE_A_TOGGLE: wave_next = cur ^ hit_a;
         WAVE_B_TOGGLE: wave_next = cur ^ hit_b;
      endcase
   endfunction

   // ==========================================================
   // State
   logic run_q, run_d;
   logic rst_busy_q, rst_busy_d;
   logic [DATA_W-1:0] count_q, count_d;
   logic [DATA_W-1:0] ctl_q, ctl_d;
   logic [DATA_W-1:0] unit_a_q, unit_a_d;
   logic [DATA_W-1:0] unit_b_q, unit_b_d;
   logic cap_a_prev_q, cap_a_prev_d;
   logic cap_b_prev_q, cap_b_prev_d;
   logic wave_a_q, wave_a_d;
   logic wave_b_q, wave_b_d;
   logic out_a_q, out_a_d;
   logic out_b_q, out_b_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic cap_a_hit, cap_b_hit, cmp_a_hit, cmp_b_hit;

   // ==========================================================
   // Next-state logic
   always_comb begin
      run_d = run_q;
      rst_busy_d = 1'b0;
      count_d = count_q;
      ctl_d = ctl_q;
      unit_a_d = unit_a_q;
      unit_b_d = unit_b_q;
      cap_a_prev_d = CAPTURE_A_IN;
      cap_b_prev_d = CAPTURE_B_IN;
      // Capture events only counted when the unit is in capture mode
      cap_a_hit = ctl_q[UNIT_A_SEL_BIT]
                  & edge_hit(ctl_q[UNIT_A_EDGE_LSB +: 2], cap_a_prev_q,
                             CAPTURE_A_IN); // see [RL4] [RL5]
      cap_b_hit = ctl_q[UNIT_B_SEL_BIT]
                  & edge_hit(ctl_q[UNIT_B_EDGE_LSB +: 2], cap_b_prev_q,
                             CAPTURE_B_IN); // see [RL2] [RL3]
      // Match checked on a tick so the output moves once per count
      cmp_a_hit = run_q & COUNT_TICK_IN & ~ctl_q[UNIT_A_SEL_BIT]
                  & (count_q == unit_a_q); // see [RL5]
      cmp_b_hit = run_q & COUNT_TICK_IN & ~ctl_q[UNIT_B_SEL_BIT]
                  & (count_q == unit_b_q); // see [RL3]
      if (run_q && COUNT_TICK_IN) begin
         count_d = count_q + ONE16;
      end
      if (cap_a_hit) begin
         unit_a_d = count_q;
      end
      if (cap_b_hit) begin
         unit_b_d = count_q;
      end
      if (WR_IN) begin
         unique case (ADDR_IN)
            CHAN_CTL_ADDR: begin
               run_d = WDATA_IN[RUN_BIT];
               if (WDATA_IN[RST_BIT]) begin
                  count_d = ZERO16; // see [RL1]
                  rst_busy_d = 1'b1;
               end
            end
            CC_CTL_ADDR: ctl_d = WDATA_IN & CC_CTL_MASK;
            UNIT_A_ADDR: unit_a_d = WDATA_IN; // see [RL6]
            UNIT_B_ADDR: unit_b_d = WDATA_IN;
            default: ;
         endcase
      end
      // Software write wins over a capture in the same cycle
      wave_a_d = wave_next(ctl_q[OUT_A_MODE_LSB +: 2], wave_a_q, cmp_a_hit,
                           cmp_b_hit); // see [RL7]
      wave_b_d = wave_next(ctl_q[OUT_B_MODE_LSB +: 2], wave_b_q, cmp_a_hit,
                           cmp_b_hit); // see [RL7]
      out_a_d = wave_a_d ^ ctl_q[OUT_A_FLIP_BIT]; // see [RL7]
      out_b_d = wave_b_d ^ ctl_q[OUT_B_FLIP_BIT]; // see [RL7]
      rdata_d = ZERO16;
      if (RD_IN) begin
         unique case (ADDR_IN)
            CHAN_CTL_ADDR: begin
               rdata_d[RUN_BIT] = run_q;
               rdata_d[RST_BIT] = rst_busy_q; // see [RL1]
            end
            COUNT_ADDR: rdata_d = count_q;
            CC_CTL_ADDR: rdata_d = ctl_q;
            UNIT_A_ADDR: rdata_d = unit_a_q; // see [RL6]
            UNIT_B_ADDR: rdata_d = unit_b_q;
            default: rdata_d = ZERO16;
         endcase
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge CORE_CLK_IN) begin
      if (RESET_IN) begin
         run_q <= 1'b0;
         rst_busy_q <= 1'b0;
         count_q <= ZERO16;
         ctl_q <= ZERO16;
         unit_a_q <= ZERO16;
         unit_b_q <= ZERO16;
         cap_a_prev_q <= 1'b0;
         cap_b_prev_q <= 1'b0;
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
         rdata_q <= ZERO16;
      end else begin
         run_q <= run_d;
         rst_busy_q <= rst_busy_d;
         count_q <= count_d;
         ctl_q <= ctl_d;
         unit_a_q <= unit_a_d;
         unit_b_q <= unit_b_d;
         cap_a_prev_q <= cap_a_prev_d;
         cap_b_prev_q <= cap_b_prev_d;
         wave_a_q <= wave_a_d;
         wave_b_q <= wave_b_d;
         out_a_q <= out_a_d;
         out_b_q <= out_b_d;
         rdata_q <= rdata_d;
      end
   end

   assign RDATA_OUT = rdata_q;
   assign TIMER_OUTPUT_A_OUT = out_a_q;
   assign TIMER_OUTPUT_B_OUT = out_b_q;
endmodule // tcc_channel

// ---- sim/tcc_checker.sv ----
// Purpose: Port assertions for tcc_channel
// Assumes: One-cycle strobes, read data one cycle late
// Notes: Output may move up to three cycles after a write or tick
`timescale 1ns/10ps
// ====
module tcc_checker import tcc_pkg::*; (
   input wire logic CORE_CLK_IN,
   input wire logic RESET_IN,
   input wire logic COUNT_TICK_IN,
   input wire logic [ADDR_W-1:0] ADDR_IN,
   input wire logic [DATA_W-1:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [DATA_W-1:0] RDATA_OUT,
   input wire logic TIMER_OUTPUT_A_OUT,
   input wire logic TIMER_OUTPUT_B_OUT
);
   logic [2:0] busy_q;
   logic [2:0] busy_d;
   always_comb busy_d = {busy_q[1:0], WR_IN | COUNT_TICK_IN};
   always_ff @(posedge CORE_CLK_IN) busy_q <= busy_d;
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (RESET_IN);
   a_read_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == ZERO16)
      else $error("read data left up");
   a_unit_a_back: assert property (WR_IN && ADDR_IN == UNIT_A_ADDR ##1
      RD_IN && ADDR_IN == UNIT_A_ADDR |=> RDATA_OUT == $past(WDATA_IN, 2))
      else $error("unit A lost data");
   a_ctl_back: assert property (WR_IN && ADDR_IN == CC_CTL_ADDR ##1
      RD_IN && ADDR_IN == CC_CTL_ADDR |=> RDATA_OUT == ($past(WDATA_IN, 2) & CC_CTL_MASK))
      else $error("control readback wrong");
   a_count_clear: assert property (WR_IN && ADDR_IN == CHAN_CTL_ADDR && WDATA_IN[RST_BIT]
      ##1 RD_IN && ADDR_IN == COUNT_ADDR |=> RDATA_OUT == ZERO16) else $error("count not cleared");
   a_ctl_reset: assert property ($fell(RESET_IN) && RD_IN && ADDR_IN == CC_CTL_ADDR
      |=> RDATA_OUT == ZERO16) else $error("control not reset");
   a_out_a_hold: assert property (busy_q == 3'h0 |-> $stable(TIMER_OUTPUT_A_OUT))
      else $error("output A moved");
   a_out_b_hold: assert property (busy_q == 3'h0 |-> $stable(TIMER_OUTPUT_B_OUT))
      else $error("output B moved");
endmodule // tcc_checker
bind tcc_channel tcc_checker u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RESET_IN(RESET_IN),
   .COUNT_TICK_IN(COUNT_TICK_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
   .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .TIMER_OUTPUT_A_OUT(TIMER_OUTPUT_A_OUT),
   .TIMER_OUTPUT_B_OUT(TIMER_OUTPUT_B_OUT));

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for tcc_channel
// Assumes: Bus tasks start just after a rising edge
// Notes: Register cases in a table, capture and outputs by hand
`timescale 1ns/10ps
// ====
module tb;
   import tcc_pkg::*;
   typedef struct {logic [15:0] a; logic [15:0] d; logic [15:0] e;} tcc_row_t;
   logic clk = 1'b0, rst = 1'b1, tick = 1'b0, cap_a = 1'b0, cap_b = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
   logic out_a, out_b;
   int mismatches = 0, n_tests = 0;
   tcc_row_t rows [9] = '{'{UNIT_A_ADDR, 16'hffff, 16'hffff}, '{UNIT_A_ADDR, 16'h8001, 16'h8001},
      '{COUNT_ADDR, 16'h1234, 16'h0000}, '{16'h5470, 16'hffff, 16'h0000},
      '{CC_CTL_ADDR, 16'hffff, 16'hf3f3}, '{CC_CTL_ADDR, 16'h4141, 16'h4141},
      '{CC_CTL_ADDR, 16'h8282, 16'h8282}, '{CC_CTL_ADDR, 16'h0000, 16'h0000},
      '{UNIT_A_ADDR, 16'h0000, 16'h0000}};
   always #25 clk = ~clk;
   tcc_channel u_tcc_channel (.CORE_CLK_IN(clk), .RESET_IN(rst), .COUNT_TICK_IN(tick),
      .CAPTURE_A_IN(cap_a), .CAPTURE_B_IN(cap_b), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .TIMER_OUTPUT_A_OUT(out_a),
      .TIMER_OUTPUT_B_OUT(out_b));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
         @(posedge clk);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd_reg(CC_CTL_ADDR, ZERO16);
      rd_reg(UNIT_A_ADDR, ZERO16);
      rd_reg(COUNT_ADDR, ZERO16);
      $display("reset values done");
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         rd_reg(rows[i].a, rows[i].e);
      end
      $display("register table done");
      wr_reg(CC_CTL_ADDR, 16'hc141);
      wr_reg(CHAN_CTL_ADDR, 16'h0001);
      pulse(5);
      cap_a <= 1'b1;
      cap_b <= 1'b1;
      repeat (2) @(posedge clk);
      pulse(2);
      cap_a <= 1'b0;
      cap_b <= 1'b0;
      repeat (2) @(posedge clk);
      rd_reg(UNIT_A_ADDR, 16'h0005);
      rd_reg(UNIT_B_ADDR, 16'h0007);
      wr_reg(CHAN_CTL_ADDR, 16'h0003);
      rd_reg(CHAN_CTL_ADDR, 16'h0003);
      rd_reg(COUNT_ADDR, ZERO16);
      wr_reg(CHAN_CTL_ADDR, 16'h0001);
      pulse(1);
      rd_reg(COUNT_ADDR, ONE16);
      wr_reg(CC_CTL_ADDR, 16'h0020);
      wr_reg(UNIT_A_ADDR, 16'h0003);
      pulse(3);
      @(posedge clk);
      #1 chk({15'h0000, out_a}, ONE16);
      wr_reg(CC_CTL_ADDR, 16'h0022);
      repeat (2) @(posedge clk);
      #1 chk({14'h0000, out_b, out_a}, ZERO16);
      // B sets/clears on A and B matches, A toggles on B match
      wr_reg(CC_CTL_ADDR, 16'h0000);
      wr_reg(CC_CTL_ADDR, 16'h1030);
      wr_reg(CHAN_CTL_ADDR, 16'h0003);
      pulse(4);
      @(posedge clk);
      #1 chk({14'h0000, out_b, out_a}, 16'h0002);
      pulse(4);
      @(posedge clk);
      #1 chk({14'h0000, out_b, out_a}, 16'h0001);
      // Falling-edge capture on A ignores the rising edge
      wr_reg(CC_CTL_ADDR, 16'h0081);
      cap_a <= 1'b1;
      repeat (2) @(posedge clk);
      pulse(1);
      cap_a <= 1'b0;
      repeat (2) @(posedge clk);
      rd_reg(UNIT_A_ADDR, 16'h0009);
      $display("capture, clear and output done");
      finish_test;
   end
   // Hang guard
   initial begin
      repeat (2000) @(posedge clk);
      mismatches++;
      finish_test;
   end
endmodule // tb
